// File: src/tpw_timebase.sv
// What this block does
// - One tick is one clock; half-period value counts ticks per half period.
// - Half-period register is 16 bits; full period is twice tick times value.
// - One 10-bit read/write dead-time register serves all three output pairs.
// - Gap between one switch off and its complement on is twice dead time ticks.
// - Dead-time zero inserts no gap between complementary transitions.
// - Mode control bit 6 clear gives single update, set gives double update.
// - Update mode bit reads zero after reset, so single update is default.
// - Single update gives exactly one sync pulse per period, at its start.
// - Each sync rising edge copies timing and duty registers to working copies.
// - The same edge copies output enable and crossover settings too.
// - Double update adds a midpoint sync pulse that reloads everything again.
// - Status bit 3 is clear in the first half period, set in the second.
// - Sync pulse drives a pin for one plus width-register ticks.
// - Sync width register resets to 0x27.
// - An interrupt request goes out with every sync pulse.
// - Timing outputs are active low; low turns the power switch on.
// - No timing outputs until half period and all duties written; half starts timer and sync.
// - High-side on-time per half is duty minus dead time, in ticks.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_cfg.svh"

module tpw_timebase
    import tpw_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             period_sync_pulse,
    output logic             sync_irq,
    output tpw_pins_t        pwm_pins
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic        aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
    logic [7:0]  aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0]  w_strb_ff, nxt_w_strb;
    logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    tpw_work_t   sw_ff, nxt_sw, wk_ff, nxt_wk;
    logic        mode_ff, nxt_mode;
    logic [3:0]  seen_ff, nxt_seen;
    tpw_state_t  state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        half_ff, nxt_half;
    logic        sync_ff, nxt_sync, irq_ff, nxt_irq;
    logic [7:0]  scnt_ff, nxt_scnt;
    tpw_pins_t   pins_ff, nxt_pins;
    logic        do_wr, boundary, fire;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic map_hit(input logic [7:0] a);
        map_hit = (a <= `TPW_OFS_STAT) && (a[1:0] == 2'b00);
    endfunction

    // Register view as software reads it
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        reg_read = 32'h0000_0000;
        case (a)
            `TPW_OFS_HALF:  reg_read[15:0] = sw_ff.half;
            `TPW_OFS_DEAD:  reg_read[9:0] = sw_ff.dead;
            `TPW_OFS_MINPW: reg_read[15:0] = sw_ff.min_pw;
            `TPW_OFS_SYNCW: reg_read[7:0] = sw_ff.sync_w;
            `TPW_OFS_DUTYA: reg_read[15:0] = sw_ff.duty_a;
            `TPW_OFS_DUTYB: reg_read[15:0] = sw_ff.duty_b;
            `TPW_OFS_DUTYC: reg_read[15:0] = sw_ff.duty_c;
            `TPW_OFS_SEG:   reg_read[8:0] = sw_ff.seg;
            `TPW_OFS_MODE:  reg_read[`TPW_MODE_DBL_BIT] = mode_ff;
            `TPW_OFS_STAT:  reg_read[`TPW_STAT_HALF_BIT] = half_ff;
            default:        reg_read = 32'h0000_0000;
        endcase
    endfunction

    // Byte-lane merge of a write into the current value
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
        end
    endfunction

    // Pair on-state {high_on, low_on} at distance pos from the period edge
    function automatic logic [1:0] pair_on(input logic [15:0] pos, input logic [15:0] h,
                                           input logic [15:0] d, input logic [9:0] t);
        logic [18:0] p, hh, dd, tt;
        p  = {3'b000, pos};
        hh = {3'b000, h};
        dd = {3'b000, d};
        tt = {9'b0_0000_0000, t};
        pair_on[1] = (p + dd) >= (hh + tt);
        pair_on[0] = (p + dd + tt) < hh;
    endfunction

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign do_wr         = aw_ok_ff && w_ok_ff && !bvalid_ff;

    // Address and data are caught in either order; response after both
    always_comb begin
        nxt_aw_ok = aw_ok_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_ok = w_ok_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_ok = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_ok = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw_ok = 1'b0;
            nxt_w_ok = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = map_hit(aw_addr_ff) ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = reg_read(s_axi_araddr);
            nxt_rresp = map_hit(s_axi_araddr) ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_ok_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else begin
            aw_ok_ff <= nxt_aw_ok;
            aw_addr_ff <= nxt_aw_addr;
            w_ok_ff <= nxt_w_ok;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Read-only status and unmapped words simply ignore writes
    always_comb begin
        logic [31:0] v;
        v = merge(reg_read(aw_addr_ff), w_data_ff, w_strb_ff);
        nxt_sw = sw_ff;
        nxt_mode = mode_ff;
        nxt_seen = seen_ff;
        if (do_wr) begin
            case (aw_addr_ff)
                `TPW_OFS_HALF: begin
                    nxt_sw.half = v[15:0];
                    nxt_seen[0] = 1'b1;
                end
                `TPW_OFS_DEAD:  nxt_sw.dead = v[9:0];
                `TPW_OFS_MINPW: nxt_sw.min_pw = v[15:0];
                `TPW_OFS_SYNCW: nxt_sw.sync_w = v[7:0];
                `TPW_OFS_DUTYA: begin
                    nxt_sw.duty_a = v[15:0];
                    nxt_seen[1] = 1'b1;
                end
                `TPW_OFS_DUTYB: begin
                    nxt_sw.duty_b = v[15:0];
                    nxt_seen[2] = 1'b1;
                end
                `TPW_OFS_DUTYC: begin
                    nxt_sw.duty_c = v[15:0];
                    nxt_seen[3] = 1'b1;
                end
                `TPW_OFS_SEG:   nxt_sw.seg = v[8:0];
                `TPW_OFS_MODE:  nxt_mode = v[`TPW_MODE_DBL_BIT];
                default:        nxt_sw = sw_ff;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_ff <= '0;
            sw_ff.sync_w <= `TPW_RST_SYNCW;
            mode_ff <= 1'b0;
            seen_ff <= 4'h0;
        end else begin
            sw_ff <= nxt_sw;
            mode_ff <= nxt_mode;
            seen_ff <= nxt_seen;
        end
    end

    // ----------------------------------------
    // Main timer and sync pulse
    // ----------------------------------------
    // 17-bit compare so a half period of all ones cannot wrap
    assign boundary = ({1'b0, cnt_ff} + 17'h0_0001) >= {1'b0, wk_ff.half};
    // Period start always syncs; midpoint only in double update
    assign fire = (state_ff == TPW_RUN) && boundary && (half_ff || mode_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_half = half_ff;
        nxt_wk = wk_ff;
        nxt_sync = sync_ff;
        nxt_scnt = scnt_ff;
        nxt_irq = 1'b0;
        case (state_ff)
            TPW_IDLE: begin
                if (seen_ff[0]) begin
                    // Single update starts mid-half so first sync lands at 1.5 halves
                    nxt_state = TPW_RUN;
                    nxt_wk = sw_ff;
                    nxt_half = 1'b0;
                    nxt_cnt = mode_ff ? 16'h0000 : {1'b0, sw_ff.half[15:1]};
                end
            end
            TPW_RUN: begin
                if (boundary) begin
                    nxt_cnt = 16'h0000;
                    nxt_half = !half_ff;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
                if (fire) begin
                    nxt_wk = sw_ff;
                end
            end
            default: nxt_state = TPW_IDLE;
        endcase
        // Width counts down from the freshly written value: high for width+1 ticks
        if (fire) begin
            nxt_sync = 1'b1;
            nxt_scnt = sw_ff.sync_w;
            nxt_irq = 1'b1;
        end else if (sync_ff) begin
            if (scnt_ff == 8'h00) begin
                nxt_sync = 1'b0;
            end else begin
                nxt_scnt = scnt_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TPW_IDLE;
            cnt_ff <= 16'h0000;
            half_ff <= 1'b0;
            wk_ff <= '0;
            sync_ff <= 1'b0;
            scnt_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            half_ff <= nxt_half;
            wk_ff <= nxt_wk;
            sync_ff <= nxt_sync;
            scnt_ff <= nxt_scnt;
            irq_ff <= nxt_irq;
        end
    end

    assign period_sync_pulse = sync_ff;
    assign sync_irq = irq_ff;

    // ----------------------------------------
    // Pair generation and output control
    // ----------------------------------------
    // Second half is mirrored so patterns stay center based
    always_comb begin
        logic [15:0] pos, duty;
        logic [1:0]  on;
        logic [5:0]  v;
        logic        run;
        pos = half_ff ? (wk_ff.half - 16'h0001 - cnt_ff) : cnt_ff;
        duty = 16'h0000;
        on = 2'b00;
        v = 6'h00;
        run = (state_ff == TPW_RUN) && (&seen_ff);
        for (int i = 0; i < 3; i++) begin
            duty = (i == 0) ? wk_ff.duty_a : (i == 1) ? wk_ff.duty_b : wk_ff.duty_c;
            on = pair_on(pos, wk_ff.half, duty, wk_ff.dead);
            if (wk_ff.seg[`TPW_SEG_XOVER_LSB + i]) begin
                on = {on[0], on[1]};
            end
            v[5 - 2*i] = on[1] && !wk_ff.seg[2*i] && run;
            v[4 - 2*i] = on[0] && !wk_ff.seg[2*i + 1] && run;
        end
        nxt_pins = tpw_pins_t'(~v);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pins_ff <= '1;
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    assign pwm_pins = pins_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_irq_with_sync;
        $rose(period_sync_pulse) |-> sync_irq;
    endproperty
    a_irq_with_sync: assert property (p_irq_with_sync) else $error("no irq with sync");

    property p_latch_cfg;
        sync_irq |-> wk_ff == $past(sw_ff);
    endproperty
    a_latch_cfg: assert property (p_latch_cfg) else $error("config not latched");

    property p_latch_seg;
        sync_irq |-> wk_ff.seg == $past(sw_ff.seg);
    endproperty
    a_latch_seg: assert property (p_latch_seg) else $error("seg not latched");

    property p_single_start;
        sync_irq && !$past(mode_ff) |-> !half_ff;
    endproperty
    a_single_start: assert property (p_single_start) else $error("single sync off start");

    property p_single_no_mid;
        $rose(half_ff) && !$past(mode_ff) |-> !sync_irq;
    endproperty
    a_single_no_mid: assert property (p_single_no_mid) else $error("mid sync in single");

    property p_double_mid;
        $rose(half_ff) && $past(mode_ff) |-> sync_irq && period_sync_pulse;
    endproperty
    a_double_mid: assert property (p_double_mid) else $error("no midpoint sync");

    property p_idle_off;
        !$past(&seen_ff) |-> pwm_pins == '1;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("output before setup");

    property p_sync_width;
        sync_irq |-> period_sync_pulse && scnt_ff == $past(sw_ff.sync_w);
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("bad sync width load");

    property p_no_overlap;
        !(!pwm_pins.phase_a_high_out && !pwm_pins.phase_a_low_out);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("pair a both on");

    c_single_sync: cover property (sync_irq && !half_ff);
    c_double_sync: cover property (sync_irq && half_ff);
    c_outputs_on: cover property (!pwm_pins.phase_a_high_out ##1 pwm_pins.phase_a_high_out);

endmodule

`default_nettype wire

// File: src/tpw_cfg.svh
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TPW_OFS_HALF   8'h00
`define TPW_OFS_DEAD   8'h04
`define TPW_OFS_MINPW  8'h08
`define TPW_OFS_SYNCW  8'h0C
`define TPW_OFS_DUTYA  8'h10
`define TPW_OFS_DUTYB  8'h14
`define TPW_OFS_DUTYC  8'h18
`define TPW_OFS_SEG    8'h1C
`define TPW_OFS_MODE   8'h20
`define TPW_OFS_STAT   8'h24

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TPW_MODE_DBL_BIT  6
`define TPW_STAT_HALF_BIT 3
`define TPW_SEG_XOVER_LSB 6
`define TPW_RST_SYNCW     8'h27
`define TPW_RESP_OKAY     2'b00
`define TPW_RESP_SLVERR   2'b10

`endif

// File: src/tpw_pkg.sv
package tpw_pkg;

    // Timer sequencing: idle until the half period is written
    typedef enum logic [1:0] {
        TPW_IDLE = 2'b00,
        TPW_RUN  = 2'b01
    } tpw_state_t;

    // Software copies and working copies share one layout
    typedef struct packed {
        logic [15:0] half;
        logic [9:0]  dead;
        logic [15:0] min_pw;
        logic [7:0]  sync_w;
        logic [15:0] duty_a;
        logic [15:0] duty_b;
        logic [15:0] duty_c;
        logic [8:0]  seg;
    } tpw_work_t;

    // Gate drive pins, active low
    typedef struct packed {
        logic phase_a_high_out;
        logic phase_a_low_out;
        logic phase_b_high_out;
        logic phase_b_low_out;
        logic phase_c_high_out;
        logic phase_c_low_out;
    } tpw_pins_t;

endpackage

// File: verif/tpw_gate_drive_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Gate driver stand-in, phase A on-times
// ----------------------------------------
module tpw_gate_drive_model
    import tpw_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst_n,
    input  wire tpw_pins_t pwm_pins,
    input  wire logic      period_sync_pulse,
    output int             hi_on,
    output int             lo_on,
    output int             both_off,
    output logic           shoot_thru
);
    int   hi_ff;
    int   lo_ff;
    int   off_ff;
    logic sync_ff;
    logic rise;
    logic a_hi;
    logic a_lo;

    // Low level turns a switch on
    assign a_hi = !pwm_pins.phase_a_high_out;
    assign a_lo = !pwm_pins.phase_a_low_out;
    assign rise = period_sync_pulse && !sync_ff;

    // Counts per window between sync rises; only full periods are
    // meaningful, since pin latency shifts the window by a cycle or two
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_ff      <= 0;
            lo_ff      <= 0;
            off_ff     <= 0;
            sync_ff    <= 1'b0;
            hi_on      <= 0;
            lo_on      <= 0;
            both_off   <= 0;
            shoot_thru <= 1'b0;
        end else begin
            sync_ff <= period_sync_pulse;
            hi_ff   <= (rise ? 0 : hi_ff) + int'(a_hi);
            lo_ff   <= (rise ? 0 : lo_ff) + int'(a_lo);
            off_ff  <= (rise ? 0 : off_ff) + int'(!a_hi && !a_lo);
            if (rise) begin
                hi_on    <= hi_ff;
                lo_on    <= lo_ff;
                both_off <= off_ff;
            end
            // Both switches of one leg on would short the dc link
            if (pwm_pins[5:4] == 2'b00 || pwm_pins[3:2] == 2'b00 || pwm_pins[1:0] == 2'b00)
                shoot_thru <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_cfg.svh"

module testbench
    import tpw_pkg::*;
;
    localparam int HALF = 20;
    localparam int DEAD = 3;
    localparam int DUTY = 12;
    localparam int SW   = 4;

    logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, psync, irq, shoot, psync_q;
    logic [1:0]  bresp, rresp;
    tpw_pins_t   pins;
    int          hi_on, lo_on, both_off, num_errors, n_tests, cyc, last_irq, irq_gap;
    int          sw_cnt, sw_len;

    tpw_timebase tpw_timebase_inst (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .period_sync_pulse(psync),
        .sync_irq(irq), .pwm_pins(pins));

    tpw_gate_drive_model tpw_gate_drive_model_inst (.mclk(mclk), .rst_n(rst_n),
        .pwm_pins(pins), .period_sync_pulse(psync), .hi_on(hi_on), .lo_on(lo_on),
        .both_off(both_off), .shoot_thru(shoot));

    // ----------------------------------------
    // Clock, checks and bus tasks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic results;
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'd0, r}, {30'd0, `TPW_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk({30'd0, r}, {30'd0, `TPW_RESP_OKAY});
    endtask

    task automatic wait_irq(input int n);
        repeat (n) begin
            do @(posedge mclk); while (irq !== 1'b1);
        end
    endtask

    // Expected on-times of phase A over one full period
    task automatic chk_legs(input int hi, input int lo, input int off);
        chk(hi_on, hi);
        chk(lo_on, lo);
        chk(both_off, off);
        chk({31'd0, shoot}, 32'd0);
    endtask

    // Sync spacing and width watcher, plus the run limit
    always @(posedge mclk) begin
        cyc     <= cyc + 1;
        psync_q <= psync;
        sw_cnt  <= psync ? sw_cnt + 1 : 0;
        if (!psync && sw_cnt != 0) sw_len <= sw_cnt;
        if (rst_n && irq) begin
            irq_gap  <= cyc - last_irq;
            last_irq <= cyc;
        end
        if (rst_n && psync && !psync_q) chk({31'd0, irq}, 32'd1);
        if (cyc >= 5000) begin
            num_errors++;
            results();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] s;
        logic [1:0]  r;
        {rst_n, awvalid, wvalid, arvalid, cyc, last_irq, irq_gap} <= '0;
        {awaddr, araddr, wdata, num_errors, n_tests, sw_cnt, sw_len, psync_q} <= '0;
        {bready, rready, wstrb} <= 6'h3F;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk(`TPW_OFS_SYNCW, 32'h0000_0027);
        rd_chk(`TPW_OFS_MODE, 32'h0000_0000);
        rd_chk(`TPW_OFS_DEAD, 32'h0000_0000);
        rd(8'h28, d, r);
        chk(d, 32'h0000_0000);
        chk({30'd0, r}, {30'd0, `TPW_RESP_SLVERR});
        wr_ok(`TPW_OFS_MINPW, 32'hFFFF_FFFF);
        rd_chk(`TPW_OFS_MINPW, 32'h0000_FFFF);
        wr(8'h2C, 32'h0000_0001, r);
        chk({30'd0, r}, {30'd0, `TPW_RESP_SLVERR});
        // Timer runs, duties unwritten: pins must stay off
        wr_ok(`TPW_OFS_HALF, HALF);
        wr_ok(`TPW_OFS_SYNCW, SW);
        wr_ok(`TPW_OFS_DEAD, DEAD);
        repeat (100) @(posedge mclk);
        chk({26'd0, pins}, 32'h0000_003F);
        wr_ok(`TPW_OFS_DUTYA, DUTY);
        wr_ok(`TPW_OFS_DUTYB, 32'h0000_0008);
        wr_ok(`TPW_OFS_DUTYC, 32'h0000_000F);
        rd_chk(`TPW_OFS_DUTYB, 32'h0000_0008);
        wait_irq(4);
        chk(irq_gap, 2 * HALF);
        chk(sw_len, SW + 1);
        chk_legs(2 * (DUTY - DEAD), 2 * (HALF - DUTY - DEAD), 4 * DEAD);
        wait_irq(1);
        rd_chk(`TPW_OFS_STAT, 32'h0000_0000);
        repeat (HALF) @(posedge mclk);
        rd_chk(`TPW_OFS_STAT, 32'h0000_0008);
        // Width limits, restored well before the next latch
        wait_irq(1);
        wr_ok(`TPW_OFS_HALF, 32'hFFFF_FFFF);
        rd_chk(`TPW_OFS_HALF, 32'h0000_FFFF);
        wr_ok(`TPW_OFS_HALF, HALF);
        wait_irq(1);
        wr_ok(`TPW_OFS_DEAD, 32'hFFFF_FFFF);
        rd_chk(`TPW_OFS_DEAD, 32'h0000_03FF);
        wr_ok(`TPW_OFS_DEAD, 32'h0000_0000);
        wait_irq(1);
        wr_ok(`TPW_OFS_SYNCW, 32'hFFFF_FFFF);
        rd_chk(`TPW_OFS_SYNCW, 32'h0000_00FF);
        wr_ok(`TPW_OFS_SYNCW, SW);
        wait_irq(4);
        chk_legs(2 * DUTY, 2 * (HALF - DUTY), 0);
        // Output control latched at sync: swap, then disable high side
        wr_ok(`TPW_OFS_SEG, 32'h0000_0040);
        rd_chk(`TPW_OFS_SEG, 32'h0000_0040);
        wait_irq(4);
        chk_legs(2 * (HALF - DUTY), 2 * DUTY, 0);
        wr_ok(`TPW_OFS_SEG, 32'h0000_0001);
        wait_irq(4);
        chk(hi_on, 0);
        chk(lo_on, 2 * (HALF - DUTY));
        wr_ok(`TPW_OFS_SEG, 32'h0000_0000);
        // Double update: sync every half, status alternates
        wr_ok(`TPW_OFS_MODE, 32'h0000_0040);
        rd_chk(`TPW_OFS_MODE, 32'h0000_0040);
        wait_irq(3);
        chk(irq_gap, HALF);
        wait_irq(1);
        wr_ok(`TPW_OFS_DUTYA, DUTY);
        rd(`TPW_OFS_STAT, d, r);
        wait_irq(1);
        wr_ok(`TPW_OFS_DUTYA, DUTY);
        rd(`TPW_OFS_STAT, s, r);
        chk({31'd0, d[3] ^ s[3]}, 32'd1);
        chk(sw_len, SW + 1);
        results();
    end
endmodule

`default_nettype wire
